// ### flash_id_cmds.sv
// Command decoder for resume, deep power-down, wake and identification reads
`include "flash_id_consts.svh"
module flash_id_cmds #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h42, // Arbitrary value
  parameter logic [7:0] CAP_CODE = 8'h2b // Arbitrary value
) (
  input wire logic ref_clk_i, // Core clock, 250 MHz
  input wire logic rst_n_i, // Power-on reset, active low
  input wire logic clk_en_i, // Freezes all state when low
  input wire logic spi_sck_i, // Serial clock pin
  input wire logic spi_cs_n_i, // Chip select pin, active low
  input wire logic [3:0] spi_io_i, // Data pins in
  input wire logic four_wire_mode_i, // Four-wire command mode
  input wire logic engine_busy_i, // Erase/program engine running
  output logic [3:0] spi_io_o, // Data pins out
  output logic [3:0] spi_io_oe_o, // Data pin drive enables
  output logic suspend_flag_o, // Suspend flag
  output logic busy_o, // Busy bit
  output logic deep_pdn_o, // In deep power-down
  output logic ready_o, // Accepting commands
  output logic suspend_req_o, // Pulse: engine must suspend
  output logic resume_req_o // Pulse: engine must resume
);
  import flash_id_pkg::*;

  logic [5:0] pin_lvl;
  logic sck_q_ff, cs_q_ff;
  phase_t phase_ff;
  id_kind_t kind_ff;
  lane_w_t lane_ff;
  logic [7:0] opc_ff, out_sr_ff;
  logic [3:0] bit_cnt_ff, out_left_ff, io_ff, oe_ff;
  logic [5:0] lat_cnt_ff, lat_len_ff, a0_idx_ff;
  logic [1:0] byte_idx_ff;
  logic addr0_ff;
  logic suspend_ff, busy_ff, resume_pend_ff, susp_req_ff, res_req_ff, ready_ff;
  logic pend_dpd_ff, pend_wake_ff, dp_wait_ff, dpd_ff, waking_ff;
  logic [11:0] dly_cnt_ff;

  spi_sync3 #(.W(6), .RST_VAL(`PIN_RST)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .async_i({spi_sck_i, spi_cs_n_i, spi_io_i}),
    .level_o(pin_lvl)
  );

  wire pin_sck = pin_lvl[5];
  wire pin_cs_n = pin_lvl[4];
  wire [3:0] pin_io = pin_lvl[3:0];
  wire cs_fall = clk_en_i & ~pin_cs_n & cs_q_ff;
  wire cs_rise = clk_en_i & pin_cs_n & ~cs_q_ff;
  wire sck_rise = clk_en_i & ~pin_cs_n & pin_sck & ~sck_q_ff;
  wire sck_fall = clk_en_i & ~pin_cs_n & ~pin_sck & sck_q_ff;

  // Opcode assembly; four-wire mode takes a nibble per edge
  wire [7:0] opc_nxt = four_wire_mode_i ? {opc_ff[3:0], pin_io} : {opc_ff[6:0], pin_io[0]};
  wire [3:0] bits_nxt = bit_cnt_ff + (four_wire_mode_i ? 4'h4 : 4'h1);
  wire opc_done = sck_rise & (phase_ff == PH_OPC) & (bits_nxt == 4'h8);
  wire is_wake = opc_nxt == `OPC_WAKE_ID;
  wire gate_ok = ~waking_ff & (~dpd_ff | is_wake);
  wire cmd_ok = opc_done & gate_ok;
  wire is_resume = cmd_ok & (opc_nxt == `OPC_RESUME);
  wire resume_ok = is_resume & suspend_ff & ~busy_ff;
  wire suspend_ok = cmd_ok & (opc_nxt == `OPC_SUSPEND) & ~suspend_ff & busy_ff;
  wire dpd_cmd = cmd_ok & (opc_nxt == `OPC_DPD);
  wire wake_cmd = cmd_ok & is_wake & ~busy_ff;
  wire spi1 = ~four_wire_mode_i;
  wire sel_md1 = cmd_ok & spi1 & (opc_nxt == `OPC_MD_ID);
  wire sel_md2 = cmd_ok & spi1 & (opc_nxt == `OPC_MD_ID_DUAL);
  wire sel_md4 = cmd_ok & spi1 & (opc_nxt == `OPC_MD_ID_QUAD);
  wire sel_dev = wake_cmd & spi1;
  wire sel_jed = cmd_ok & (opc_nxt == `OPC_JEDEC_ID);
  wire id_any = sel_md1 | sel_md2 | sel_md4 | sel_dev | sel_jed;

  wire [5:0] nxt_lat = sel_md2 ? `LAT_DUAL : sel_md4 ? `LAT_QUAD :
                       sel_jed ? `LAT_NONE : `LAT_SINGLE;
  wire [5:0] nxt_a0 = sel_md2 ? `A0_DUAL : sel_md4 ? `A0_QUAD : `A0_SINGLE;
  wire lane_t4 = sel_md4 | (sel_jed & four_wire_mode_i);
  wire [2:0] nxt_lane = sel_md2 ? 3'h2 : lane_t4 ? 3'h4 : 3'h1;
  wire [5:0] lat_nxt = lat_cnt_ff + 6'h01;
  wire [1:0] kind_sel = sel_jed ? 2'h2 : sel_dev ? 2'h1 : 2'h0;

  // Byte sequence for the current identification read
  wire [7:0] md_byte = (byte_idx_ff[0] ^ addr0_ff) ? DEV_CODE : MFR_CODE;
  wire [7:0] jed_byte = (byte_idx_ff == 2'h0) ? MFR_CODE :
                        (byte_idx_ff == 2'h1) ? MEM_TYPE : CAP_CODE;
  wire [7:0] next_byte = (kind_ff == ID_JEDEC) ? jed_byte :
                         (kind_ff == ID_DEV) ? DEV_CODE : md_byte;
  wire load = out_left_ff == 4'h0;
  wire [7:0] cur_byte = load ? next_byte : out_sr_ff;
  wire jed_wrap = (kind_ff == ID_JEDEC) & (byte_idx_ff == 2'h2);
  wire [1:0] nxt_idx = !load ? byte_idx_ff : jed_wrap ? 2'h0 : byte_idx_ff + 2'h1;
  wire [3:0] nxt_io = (lane_ff == 3'h4) ? cur_byte[7:4] :
                      (lane_ff == 3'h2) ? {2'b00, cur_byte[7:6]} : {2'b00, cur_byte[7], 1'b0};
  wire [3:0] nxt_oe = (lane_ff == 3'h4) ? 4'hf : (lane_ff == 3'h2) ? 4'h3 : 4'h2;
  wire [3:0] nxt_left = (load ? 4'h8 : out_left_ff) - {1'b0, lane_ff};
  wire [7:0] nxt_sr = cur_byte << lane_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
    end else if (clk_en_i) begin
      sck_q_ff <= pin_sck;
      cs_q_ff <= pin_cs_n;
    end
  end

  // Command sequencing; a chip select edge always wins over clock edges
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= PH_IDLE;
      kind_ff <= ID_MD;
      lane_ff <= 3'h1;
      opc_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      lat_cnt_ff <= 6'h00;
      lat_len_ff <= 6'h00;
      a0_idx_ff <= 6'h00;
      addr0_ff <= 1'b0;
      out_sr_ff <= 8'h00;
      out_left_ff <= 4'h0;
      byte_idx_ff <= 2'h0;
      io_ff <= 4'h0;
      oe_ff <= 4'h0;
    end else if (cs_rise) begin
      phase_ff <= PH_IDLE;
      oe_ff <= 4'h0;
    end else if (cs_fall) begin
      phase_ff <= PH_OPC;
      bit_cnt_ff <= 4'h0;
      out_left_ff <= 4'h0;
      byte_idx_ff <= 2'h0;
      addr0_ff <= 1'b0;
    end else begin
      unique case (phase_ff)
        PH_OPC: if (sck_rise) begin
          opc_ff <= opc_nxt;
          bit_cnt_ff <= bits_nxt;
          if (opc_done) begin
            phase_ff <= !id_any ? PH_DONE : (nxt_lat == `LAT_NONE) ? PH_DATA : PH_ADDR;
            lat_cnt_ff <= 6'h00;
            lat_len_ff <= nxt_lat;
            a0_idx_ff <= nxt_a0;
            lane_ff <= nxt_lane;
            kind_ff <= id_kind_t'(kind_sel);
          end
        end
        PH_ADDR: if (sck_rise) begin
          lat_cnt_ff <= lat_nxt;
          if (lat_cnt_ff == a0_idx_ff) begin
            addr0_ff <= pin_io[0];
          end
          if (lat_nxt == lat_len_ff) begin
            phase_ff <= PH_DATA;
          end
        end
        PH_DATA: if (sck_fall) begin
          io_ff <= nxt_io;
          oe_ff <= nxt_oe;
          out_sr_ff <= nxt_sr;
          out_left_ff <= nxt_left;
          byte_idx_ff <= nxt_idx;
        end
        PH_IDLE, PH_DONE: begin
        end
      endcase
    end
  end

  // Power-down entry armed only at the exact opcode boundary; a wake stays armed through later clocks until chip select falls
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_dpd_ff <= 1'b0;
      pend_wake_ff <= 1'b0;
    end else if (cs_fall) begin
      pend_dpd_ff <= 1'b0;
      pend_wake_ff <= 1'b0;
    end else if (sck_rise && opc_done) begin
      pend_dpd_ff <= dpd_cmd;
      pend_wake_ff <= wake_cmd;
    end else if (sck_rise) begin
      pend_dpd_ff <= 1'b0;
    end
  end

  // Power state; reset is power-up, so standby is always the start
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wait_ff <= 1'b0;
      dpd_ff <= 1'b0;
      waking_ff <= 1'b0;
      dly_cnt_ff <= 12'h000;
    end else if (cs_rise && pend_wake_ff && (dpd_ff || dp_wait_ff)) begin
      waking_ff <= 1'b1;
      dp_wait_ff <= 1'b0;
      dly_cnt_ff <= 12'(`WAKE_CYC - 1);
    end else if (cs_rise && pend_dpd_ff && !dpd_ff) begin
      dp_wait_ff <= 1'b1;
      dly_cnt_ff <= 12'(`DP_CYC - 1);
    end else if (clk_en_i && (dp_wait_ff || waking_ff)) begin
      if (dly_cnt_ff == 12'h000) begin
        dpd_ff <= dp_wait_ff;
        dp_wait_ff <= 1'b0;
        waking_ff <= 1'b0;
      end else begin
        dly_cnt_ff <= dly_cnt_ff - 12'h001;
      end
    end
  end

  // Suspend state is not kept across power loss, so a stale resume is refused
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      suspend_ff <= 1'b0;
      resume_pend_ff <= 1'b0;
      busy_ff <= 1'b0;
      susp_req_ff <= 1'b0;
      res_req_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (clk_en_i) begin
      suspend_ff <= suspend_ok | (suspend_ff & ~resume_ok);
      resume_pend_ff <= resume_ok | (resume_pend_ff & ~engine_busy_i);
      busy_ff <= engine_busy_i | resume_ok | resume_pend_ff;
      susp_req_ff <= suspend_ok;
      res_req_ff <= resume_ok;
      ready_ff <= ~busy_ff & ~dpd_ff & ~waking_ff & ~dp_wait_ff;
    end
  end

  assign spi_io_o = io_ff;
  assign spi_io_oe_o = oe_ff;
  assign suspend_flag_o = suspend_ff;
  assign busy_o = busy_ff;
  assign deep_pdn_o = dpd_ff;
  assign ready_o = ready_ff;
  assign suspend_req_o = susp_req_ff;
  assign resume_req_o = res_req_ff;

  // Checks
  localparam int RB_LIM = `RESUME_BUSY_CYC;
  logic [11:0] dp_age_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_age_ff <= 12'h000;
    end else if (clk_en_i) begin
      // A repeated entry command restarts the delay, so the age restarts too
      dp_age_ff <= (dp_wait_ff && !(cs_rise && pend_dpd_ff)) ? dp_age_ff + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_resume_taken;
    res_req_ff && !suspend_ff;
  endsequence

  AST_RESUME_GATE: assert property (
    res_req_ff |-> $past(suspend_ff) && !$past(busy_ff))
    else $error("resume taken without suspend or while busy");
  AST_RESUME_BUSY: assert property (
    s_resume_taken |-> ##[0:RB_LIM] busy_ff)
    else $error("busy not raised after resume");
  AST_RESUME_IGNORED: assert property (
    (is_resume && !(suspend_ff && !busy_ff)) |=> !res_req_ff && $stable(suspend_ff))
    else $error("refused resume changed state");
  AST_DPD_BOUNDARY: assert property (
    $rose(dp_wait_ff) |-> $past(pend_dpd_ff) && $past(cs_rise))
    else $error("power-down armed off the opcode boundary");
  AST_DPD_DELAY: assert property (
    $rose(dpd_ff) |-> dp_age_ff == 12'(`DP_CYC))
    else $error("power-down entered at wrong delay");
  AST_DPD_ONLY_WAKE: assert property (
    (opc_done && dpd_ff && !is_wake) |=> phase_ff == PH_DONE && !pend_dpd_ff)
    else $error("command honoured in power-down");
  AST_WAKE_PATH: assert property (
    $fell(dpd_ff) |-> $past(waking_ff) && !ready_ff)
    else $error("power-down left without wake delay");
  AST_FOUR_WIRE_WAKE_ONLY: assert property (
    (cmd_ok && is_wake && four_wire_mode_i) |=> phase_ff == PH_DONE)
    else $error("four-wire wake started a code read");
  AST_BUSY_WAKE: assert property (
    (cmd_ok && is_wake && busy_ff) |=> !pend_wake_ff && phase_ff == PH_DONE)
    else $error("wake honoured while busy");
  AST_DRIVE_IN_DATA: assert property (
    (spi_io_oe_o != 4'h0) |-> phase_ff == PH_DATA)
    else $error("data pins driven outside data phase");
  AST_SUSPEND: assert property (
    susp_req_ff |-> suspend_ff && $past(busy_ff) && !$past(suspend_ff))
    else $error("suspend flag not set on accepted suspend");
  AST_CS_RESTART: assert property (
    (cs_fall && !cs_rise) |=> phase_ff == PH_OPC && bit_cnt_ff == 4'h0)
    else $error("decode not restarted on chip select fall");
endmodule

// ### flash_id_consts.svh
// Opcodes, latencies and timing counts for the flash command decoder
`ifndef FLASH_ID_CONSTS_SVH
`define FLASH_ID_CONSTS_SVH

`define OPC_RESUME 8'h7a
`define OPC_SUSPEND 8'h75
`define OPC_DPD 8'hb9
`define OPC_WAKE_ID 8'hab
`define OPC_MD_ID 8'h90
`define OPC_MD_ID_DUAL 8'h92
`define OPC_MD_ID_QUAD 8'h94
`define OPC_JEDEC_ID 8'h9f

// Serial clocks between opcode and first data bit
`define LAT_SINGLE 6'h18
`define LAT_DUAL 6'h10
`define LAT_QUAD 6'h0c
`define LAT_NONE 6'h00

// Serial clock index that carries address bit 0
`define A0_SINGLE 6'h17
`define A0_DUAL 6'h0b
`define A0_QUAD 6'h05

// Pin reset levels: sck low, chip select high, data low
`define PIN_RST 6'h10

`define CLK_MHZ 250
`define T_DP_NS 3000
`define T_WAKE_NS 3000
`define T_RESUME_BUSY_NS 200
`define DP_CYC ((`T_DP_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_CYC ((`T_WAKE_NS * `CLK_MHZ + 999) / 1000)
`define RESUME_BUSY_CYC (`T_RESUME_BUSY_NS * `CLK_MHZ / 1000)

`endif

// ### flash_id_pkg.sv
// Types shared by the flash command decoder
package flash_id_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_DATA, PH_DONE} phase_t;
  typedef enum logic [1:0] {ID_MD, ID_DEV, ID_JEDEC} id_kind_t;
  typedef logic [2:0] lane_w_t;
endpackage

// ### spi_sync3.sv
// Three-stage pin synchroniser with agreement filter
module spi_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic clk_en_i, // Freezes state when low
  input wire logic [W-1:0] async_i, // Pins from outside the domain
  output logic [W-1:0] level_o // Filtered levels
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff;
  wire [W-1:0] agree = s2_ff ~^ s3_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_o <= RST_VAL;
    end else if (clk_en_i) begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_o <= (agree & s3_ff) | (~agree & level_o);
    end
  end
endmodule

// ### flash_host_model.sv
// Host controller model driving the serial flash pins
module flash_host_model (
  output logic spi_sck_o, // Serial clock, idles low between frames
  output logic spi_cs_n_o, // Chip select, active low
  output logic [3:0] host_io_o, // Host side of the data pins
  input wire logic [3:0] pin_io_i // Resolved data pin levels
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;

  initial begin
    spi_sck_o = 1'b0;
    spi_cs_n_o = 1'b1;
    host_io_o = 4'h0;
  end

  task automatic pulse();
    #HALF;
    spi_sck_o = 1'b1;
    #HALF;
    spi_sck_o = 1'b0;
  endtask

  // One framed command: opcode, lat address/mode/dummy clocks, nrd read clocks
  task automatic xfer(input logic [7:0] opc, input logic [23:0] adr, input int lanes,
                      input int lat, input bit fw, input int nrd, output logic [31:0] rd);
    int k;
    logic [3:0] nib;
    rd = '0;
    #250;
    spi_cs_n_o = 1'b0;
    for (k = 0; k < (fw ? 2 : 8); k++) begin
      host_io_o = fw ? (k == 0 ? opc[7:4] : opc[3:0]) : {3'h0, opc[7-k]};
      pulse();
    end
    for (k = 0; k < lat; k++) begin
      nib = (k * lanes < 24) ? 4'(adr >> (24 - (k + 1) * lanes)) : 4'h0;
      host_io_o = nib & 4'((5'h1 << lanes) - 5'h1);
      pulse();
    end
    for (k = 0; k < nrd; k++) begin
      // Released lines toggle so a stale value never reads as data
      host_io_o = ~host_io_o;
      #HALF;
      rd = (rd << lanes) | (lanes == 1 ? pin_io_i[1] : lanes == 2 ? pin_io_i[1:0] : pin_io_i);
      spi_sck_o = 1'b1;
      #HALF;
      spi_sck_o = 1'b0;
    end
    #HALF;
    spi_cs_n_o = 1'b1;
    host_io_o = ~host_io_o;
  endtask
endmodule

// ### flash_resume_sleep_id_cmds_test.sv
// Self-checking bench for the flash command decoder
`include "flash_id_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module flash_resume_sleep_id_cmds_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
  localparam logic [7:0] TYP = 8'h42; // Arbitrary value
  localparam logic [7:0] CAP = 8'h2b; // Arbitrary value
  typedef struct {
    logic [7:0] opc; logic [23:0] adr; int lanes; int lat; bit fw; bit eng;
    logic [3:0] oe; logic [31:0] exp;
  } row_t;
  row_t rows [11] = '{
    '{`OPC_MD_ID, 24'h0, 1, 24, 0, 0, 4'h2, {MFR, DEV, MFR, DEV}},
    '{`OPC_MD_ID, 24'h1, 1, 24, 0, 0, 4'h2, {DEV, MFR, DEV, MFR}},
    '{`OPC_MD_ID_DUAL, 24'h0, 2, 16, 0, 0, 4'h3, {MFR, DEV, MFR, DEV}},
    '{`OPC_MD_ID_DUAL, 24'h1, 2, 16, 0, 0, 4'h3, {DEV, MFR, DEV, MFR}},
    '{`OPC_MD_ID_QUAD, 24'h0, 4, 12, 0, 0, 4'hf, {MFR, DEV, MFR, DEV}},
    '{`OPC_MD_ID_QUAD, 24'h1, 4, 12, 0, 0, 4'hf, {DEV, MFR, DEV, MFR}},
    '{`OPC_JEDEC_ID, 24'h0, 1, 0, 0, 0, 4'h2, {MFR, TYP, CAP, MFR}},
    '{`OPC_JEDEC_ID, 24'h0, 4, 0, 1, 0, 4'hf, {MFR, TYP, CAP, MFR}},
    '{`OPC_WAKE_ID, 24'h0, 1, 24, 0, 0, 4'h2, {DEV, DEV, DEV, DEV}},
    '{`OPC_WAKE_ID, 24'h0, 4, 6, 1, 0, 4'h0, 32'h0},
    '{`OPC_WAKE_ID, 24'h0, 1, 24, 0, 1, 4'h0, 32'h0}
  };
  logic ref_clk_i, rst_n_i, clk_en, four_wire, eng_busy, sck, cs_n;
  logic susp_flag, busy, pdn, rdy, susp_req, res_req;
  logic [3:0] host_io, io_o, io_oe, oe_acc;
  logic [31:0] rd;
  wire [3:0] pin_io = (io_oe & io_o) | (~io_oe & host_io);
  int failures = 0;
  int checks_done = 0;
  int susp_cnt = 0;
  int res_cnt = 0;
  int n;

  flash_id_cmds #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(TYP), .CAP_CODE(CAP)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_io_i(pin_io), .four_wire_mode_i(four_wire),
    .engine_busy_i(eng_busy), .spi_io_o(io_o), .spi_io_oe_o(io_oe),
    .suspend_flag_o(susp_flag), .busy_o(busy), .deep_pdn_o(pdn), .ready_o(rdy),
    .suspend_req_o(susp_req), .resume_req_o(res_req));
  flash_host_model host_u (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .host_io_o(host_io),
    .pin_io_i(pin_io));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // One-cycle pulses are counted in the cycle that they stand
  always @(posedge ref_clk_i) begin
    if (susp_req === 1'b1) susp_cnt++;
    if (res_req === 1'b1) res_cnt++;
    if (cs_n === 1'b0) oe_acc |= io_oe;
  end

  task automatic end_sim();
    $display("Counts: %0d checks, %0d failures", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] opc, input int lat);
    host_u.xfer(opc, 24'h0, 1, lat, 1'b0, 0, rd);
    repeat (10) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wait_pdn(input logic v, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge ref_clk_i);
      #1;
      if (pdn === v) break;
    end
    if (cnt == lim) begin
      failures++;
      end_sim();
    end
  endtask

  initial begin
    #400000;
    failures++;
    end_sim();
  end

  initial begin
    rst_n_i = 1'b0;
    clk_en = 1'b1;
    four_wire = 1'b0;
    eng_busy = 1'b0;
    oe_acc = 4'h0;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1;
    `CHK(rdy, 1'b1);
    `CHK({pdn, susp_flag, io_oe}, 6'h00);
    foreach (rows[i]) begin
      four_wire = rows[i].fw;
      eng_busy = rows[i].eng;
      oe_acc = 4'h0;
      host_u.xfer(rows[i].opc, rows[i].adr, rows[i].lanes, rows[i].lat, rows[i].fw,
                  32 / rows[i].lanes, rd);
      repeat (10) @(posedge ref_clk_i);
      #1;
      `CHK(oe_acc, rows[i].oe);
      if (rows[i].oe != 4'h0) `CHK(rd, rows[i].exp);
      `CHK(io_oe, 4'h0);
    end
    four_wire = 1'b0;
    eng_busy = 1'b1;
    cmd(`OPC_SUSPEND, 0);
    `CHK({susp_flag, susp_cnt}, {1'b1, 32'd1});
    cmd(`OPC_RESUME, 0);
    `CHK({susp_flag, res_cnt}, {1'b1, 32'd0});
    eng_busy = 1'b0;
    cmd(`OPC_RESUME, 0);
    `CHK({susp_flag, busy, res_cnt}, {2'b01, 32'd1});
    cmd(`OPC_RESUME, 0);
    `CHK(res_cnt, 1);
    eng_busy = 1'b1;
    // Engine restarted; keep clear of the guard time before suspending again
    repeat (100) @(posedge ref_clk_i);
    cmd(`OPC_SUSPEND, 0);
    `CHK(susp_cnt, 2);
    eng_busy = 1'b0;
    cmd(`OPC_DPD, 1);
    repeat (`DP_CYC + 20) @(posedge ref_clk_i);
    #1 `CHK(pdn, 1'b0);
    host_u.xfer(`OPC_DPD, 24'h0, 1, 0, 1'b0, 0, rd);
    wait_pdn(1'b1, `DP_CYC + 20, n);
    `CHK(n >= `DP_CYC, 1'b1);
    oe_acc = 4'h0;
    host_u.xfer(`OPC_JEDEC_ID, 24'h0, 1, 0, 1'b0, 32, rd);
    cmd(`OPC_RESUME, 0);
    `CHK({oe_acc, pdn, susp_flag, res_cnt}, {6'h03, 32'd1});
    host_u.xfer(`OPC_WAKE_ID, 24'h0, 1, 0, 1'b0, 0, rd);
    wait_pdn(1'b0, `WAKE_CYC + 20, n);
    `CHK(n >= `WAKE_CYC, 1'b1);
    @(posedge ref_clk_i);
    #1 `CHK(rdy, 1'b1);
    host_u.xfer(`OPC_DPD, 24'h0, 1, 0, 1'b0, 0, rd);
    // Enable drops while the chip select rise is still in the synchroniser, so entry must not start while it is low
    @(posedge ref_clk_i);
    #1 clk_en = 1'b0;
    repeat (200) @(posedge ref_clk_i);
    #1 `CHK(pdn, 1'b0);
    clk_en = 1'b1;
    wait_pdn(1'b1, `DP_CYC + 20, n);
    `CHK(n >= `DP_CYC - 8, 1'b1);
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    #1 `CHK({pdn, susp_flag, rdy}, 3'b001);
    cmd(`OPC_RESUME, 0);
    `CHK({susp_flag, res_cnt}, {1'b0, 32'd1});
    end_sim();
  end
endmodule
